// >>> hhb_serial_ctrl.sv
// Serial command front end and bridge control of a six-channel half-bridge driver.
// Assumes a host master on sclk/chip_select_n; fault inputs come from analog monitors.
`timescale 1ns/1ps
module hhb_serial_ctrl
  import hhb_pkg::*;
(
  // System clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Device enable pin
  input wire logic device_enable,
  // Serial link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  // Analog monitors
  input wire hhb_fault_t fault_in,
  // Drivers and ready flag
  output logic [5:0] high_side_on,
  output logic [5:0] low_side_on,
  output logic device_ready
);

  // ----------------------------------------
  // Link domain: receive and count
  // ----------------------------------------
  logic link_clr;
  logic [15:0] rx_sr;
  logic [4:0] head_cnt;
  logic [2:0] tail_cnt;
  logic [15:0] cap_word;
  logic cap_ok;
  logic cap_tog;
  logic [4:0] rise_cnt;
  logic first_r;
  logic so_r;
  logic [15:0] diag_snap_r;
  logic tsd_snap_r;
  logic head_full;
  logic frame_ok;
  logic [3:0] tx_idx;

  // Counters clear while the frame is closed, so no edge is needed outside a frame
  assign link_clr = chip_select_n | ~rstn;
  assign head_full = (head_cnt == HEAD_BITS);
  assign frame_ok = head_full && (tail_cnt == 3'h0);
  assign tx_idx = LAST_BIT - rise_cnt[3:0];

  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      rx_sr <= CMD_RST;
    end else begin
      rx_sr <= {rx_sr[14:0], serial_in};
    end
  end

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      head_cnt <= 5'h00;
      tail_cnt <= 3'h0;
    end else if (!head_full) begin
      head_cnt <= head_cnt + 5'h01;
    end else begin
      tail_cnt <= tail_cnt + 3'h1;
    end
  end

  // Frame close: hold word and verdict for the system domain
  always_ff @(posedge chip_select_n or negedge rstn) begin
    if (!rstn) begin
      cap_word <= CMD_RST;
      cap_ok <= 1'b0;
      cap_tog <= 1'b0;
    end else begin
      cap_word <= rx_sr;
      cap_ok <= frame_ok;
      cap_tog <= ~cap_tog;
    end
  end

  // ----------------------------------------
  // Link domain: transmit
  // ----------------------------------------
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      rise_cnt <= 5'h00;
      first_r <= 1'b1;
      so_r <= 1'b0;
    end else begin
      first_r <= 1'b0;
      if (!rise_cnt[4]) begin
        so_r <= diag_snap_r[tx_idx];
        rise_cnt <= rise_cnt + 5'h01;
      end else begin
        // Daisy chain: pass on what came in 16 bits earlier
        so_r <= rx_sr[15];
      end
    end
  end

  // Pseudo bit sits ahead of the first rising edge; a mux is unavoidable here
  assign serial_out = first_r ? tsd_snap_r : so_r;
  assign serial_out_oe_n = chip_select_n;

  // ----------------------------------------
  // System domain: synchronisers
  // ----------------------------------------
  logic en_s1, en_s2;
  logic cs_s1, cs_s2;
  logic tog_s1, tog_s2, tog_s3;
  hhb_fault_t flt_s1, flt_s2;
  logic frame_end;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      flt_s1 <= '0;
      flt_s2 <= '0;
    end else begin
      en_s1 <= device_enable;
      en_s2 <= en_s1;
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      tog_s1 <= cap_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      flt_s1 <= fault_in;
      flt_s2 <= flt_s1;
    end
  end

  assign frame_end = tog_s2 ^ tog_s3;

  // ----------------------------------------
  // System domain: power state
  // ----------------------------------------
  hhb_state_t state_r, state_nxt;
  logic [9:0] por_cnt_r, por_cnt_nxt;
  logic run;

  always_comb begin
    state_nxt = state_r;
    por_cnt_nxt = 10'h000;
    unique case (state_r)
      HHB_SLEEP: if (en_s2) state_nxt = HHB_POR;
      HHB_POR: begin
        por_cnt_nxt = por_cnt_r + 10'h001;
        if (por_cnt_r == POR_LAST) state_nxt = HHB_RUN;
      end
      HHB_RUN: state_nxt = HHB_RUN;
      default: state_nxt = HHB_SLEEP;
    endcase
    if (!en_s2) state_nxt = HHB_SLEEP;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= HHB_SLEEP;
      por_cnt_r <= 10'h000;
    end else begin
      state_r <= state_nxt;
      por_cnt_r <= por_cnt_nxt;
    end
  end

  assign run = (state_r == HHB_RUN);

  // ----------------------------------------
  // System domain: command and faults
  // ----------------------------------------
  logic [15:0] bridge_command_word_r, cmd_nxt;
  logic [10:0] gap_r, gap_nxt;
  logic accept, clr_req;
  logic ocs_r, tsd_r, ocs_nxt, tsd_nxt;
  logic [5:0] uld_r, uld_nxt;
  logic supply_fault_flag;
  logic [5:0] bridge_output_enable, bridge_direction_select;
  logic underload_shutdown_enable, overvoltage_lockout_enable;

  // Frames outside the run state are never serviced
  assign accept = frame_end && cap_ok && run;
  assign clr_req = accept && cap_word[B_CLR] && (gap_r >= CLR_GAP);
  assign cmd_nxt = accept ? cap_word : bridge_command_word_r;
  assign gap_nxt = frame_end ? 11'h000 : ((gap_r >= CLR_GAP) ? gap_r : gap_r + 11'h001);
  // Set wins over the clear
  assign ocs_nxt = flt_s2.overcurrent | (ocs_r & ~clr_req);
  assign tsd_nxt = flt_s2.thermal_shutdown | (tsd_r & ~clr_req);
  assign uld_nxt = flt_s2.underload | (uld_r & {NBR{~clr_req}});
  assign supply_fault_flag = flt_s2.overvoltage | flt_s2.undervoltage;
  // Bit 14 is left unused on purpose
  assign bridge_output_enable = bridge_command_word_r[B_EN_LO +: NBR];
  assign bridge_direction_select = bridge_command_word_r[B_DIR_LO +: NBR];
  assign underload_shutdown_enable = bridge_command_word_r[B_ULSD];
  assign overvoltage_lockout_enable = bridge_command_word_r[B_OVERVOLTAGE_LOCKOUT_ENABLE];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bridge_command_word_r <= CMD_RST;
      gap_r <= CLR_GAP;
      ocs_r <= 1'b0;
      tsd_r <= 1'b0;
      uld_r <= 6'h00;
    end else if (!en_s2) begin
      bridge_command_word_r <= CMD_RST;
      gap_r <= CLR_GAP;
      ocs_r <= 1'b0;
      tsd_r <= 1'b0;
      uld_r <= 6'h00;
    end else begin
      bridge_command_word_r <= cmd_nxt;
      gap_r <= gap_nxt;
      ocs_r <= ocs_nxt;
      tsd_r <= tsd_nxt;
      uld_r <= uld_nxt;
    end
  end

  // ----------------------------------------
  // System domain: bridge drive
  // ----------------------------------------
  hhb_drive_t drv_r [NBR];
  hhb_drive_t drv_nxt [NBR];
  logic [3:0] dt_r [NBR];
  logic [3:0] dt_nxt [NBR];
  logic [5:0] want_on;
  logic [5:0] enabled_now;
  logic global_off;

  assign global_off = ~run | ocs_r | tsd_r | (overvoltage_lockout_enable & flt_s2.overvoltage);
  assign want_on = bridge_output_enable & ~{NBR{global_off}}
    & ~({NBR{underload_shutdown_enable}} & uld_r);

  always_comb begin
    hhb_drive_t tgt;
    tgt = DRV_OFF;
    for (int i = 0; i < NBR; i++) begin
      tgt = want_on[i] ? (bridge_direction_select[i] ? DRV_HS : DRV_LS) : DRV_OFF;
      drv_nxt[i] = drv_r[i];
      dt_nxt[i] = 4'h0;
      if (drv_r[i] == tgt) begin
        drv_nxt[i] = drv_r[i];
      end else if (drv_r[i] != DRV_OFF) begin
        // Always pass through off; never swap sides directly
        drv_nxt[i] = DRV_OFF;
      end else if (dt_r[i] == DEAD_LAST) begin
        drv_nxt[i] = tgt;
      end else begin
        dt_nxt[i] = dt_r[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NBR; i++) begin
        drv_r[i] <= DRV_OFF;
        dt_r[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < NBR; i++) begin
        drv_r[i] <= en_s2 ? drv_nxt[i] : DRV_OFF;
        dt_r[i] <= en_s2 ? dt_nxt[i] : 4'h0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NBR; i++) begin
      high_side_on[i] = drv_r[i].hs;
      low_side_on[i] = drv_r[i].ls;
      enabled_now[i] = drv_r[i].hs | drv_r[i].ls;
    end
  end

  // ----------------------------------------
  // Diagnostic snapshot
  // ----------------------------------------
  // Frozen while a frame is open so the link sees a stable word
  logic [15:0] diag_w;
  assign diag_w = {ocs_r, supply_fault_flag, |uld_r, enabled_now, bridge_direction_select, flt_s2.thermal_warning};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      diag_snap_r <= DIAG_RST;
      tsd_snap_r <= 1'b0;
      device_ready <= 1'b0;
    end else begin
      if (cs_s2) begin
        diag_snap_r <= diag_w;
        tsd_snap_r <= tsd_r;
      end
      device_ready <= run;
    end
  end

endmodule

// >>> hhb_pkg.sv
// Constants and types for the hex half-bridge serial control block.
// Assumes a 10 MHz system clock; the serial clock comes from the host.
package hhb_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int DEAD_NS = 1500;
  localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int POR_US = 100;
  localparam int POR_CYC = (POR_US * 1000) / CLK_NS;
  localparam int CLR_GAP_US = 150;
  localparam int CLR_GAP_CYC = (CLR_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] DEAD_LAST = 4'(DEAD_CYC - 1);
  localparam logic [9:0] POR_LAST = 10'(POR_CYC - 1);
  localparam logic [10:0] CLR_GAP = 11'(CLR_GAP_CYC);

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int NBR = 6;
  localparam logic [4:0] HEAD_BITS = 5'h10;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam int B_CLR = 15;
  localparam int B_SEL = 14;
  localparam int B_ULSD = 13;
  localparam int B_EN_LO = 7;
  localparam int B_DIR_LO = 1;
  localparam int B_OVERVOLTAGE_LOCKOUT_ENABLE = 0;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] DIAG_RST = 16'h0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    HHB_SLEEP = 2'b00,
    HHB_POR = 2'b01,
    HHB_RUN = 2'b10
  } hhb_state_t;

  typedef struct packed {
    logic overvoltage;
    logic undervoltage;
    logic overcurrent;
    logic thermal_shutdown;
    logic thermal_warning;
    logic [5:0] underload;
  } hhb_fault_t;

  typedef struct packed {
    logic hs;
    logic ls;
  } hhb_drive_t;

  localparam hhb_drive_t DRV_OFF = 2'b00;
  localparam hhb_drive_t DRV_HS = 2'b10;
  localparam hhb_drive_t DRV_LS = 2'b01;
endpackage

// >>> hhb_serial_ctrl_properties.sv
// Assertions on the ports of the half-bridge serial control block.
// Bound into the design from the bench top; one mclk domain.
`timescale 1ns/1ps
module hhb_serial_ctrl_properties
  import hhb_pkg::*;
(
  // Clocks and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk,
  // Inputs
  input wire logic device_enable,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire hhb_fault_t fault_in,
  // Outputs
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic [5:0] high_side_on,
  input wire logic [5:0] low_side_on,
  input wire logic device_ready
);
  // ------
  // Helpers
  // ------
  // Counters keep long spans out of repetition
  logic [10:0] en_cnt_r;
  logic [4:0] gap_r;
  wire [5:0] drv = high_side_on | low_side_on;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      en_cnt_r <= 11'h000;
      gap_r <= 5'h00;
    end else begin
      en_cnt_r <= device_enable ? en_cnt_r + 11'(en_cnt_r != 11'h7FF) : 11'h000;
      gap_r <= drv[0] ? 5'h00 : gap_r + 5'(gap_r != 5'h1F);
    end
  end
  // ------
  // Properties
  // ------
  sequence s_asleep;
    !device_enable [*5];
  endsequence
  sequence s_off;
    drv == 6'h00;
  endsequence
  property p_oe;
    serial_out_oe_n == chip_select_n;
  endproperty
  property p_excl;
    (high_side_on & low_side_on) == 6'h00;
  endproperty
  property p_dead;
    $rose(drv[0]) |-> gap_r >= 5'h0F;
  endproperty
  property p_sleep;
    s_asleep |-> s_off and !device_ready;
  endproperty
  property p_por_min;
    $rose(device_ready) |-> en_cnt_r >= 11'h3E8;
  endproperty
  property p_por_max;
    en_cnt_r == 11'h3F2 |-> device_ready;
  endproperty
  property p_run;
    drv != 6'h00 |-> device_ready || $past(device_ready);
  endproperty
  property p_tsd;
    $rose(fault_in.thermal_shutdown) |-> ##[1:5] s_off;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable differs from select");
  a_excl: assert property (p_excl) else $error("both sides on");
  a_dead: assert property (p_dead) else $error("dead time too short");
  a_sleep: assert property (p_sleep) else $error("drivers on in sleep");
  a_por_min: assert property (p_por_min) else $error("ready too early");
  a_por_max: assert property (p_por_max) else $error("ready too late");
  a_run: assert property (p_run) else $error("drivers on outside run");
  a_tsd: assert property (p_tsd) else $error("no shutdown on thermal fault");
endmodule

// >>> hhb_host_model.sv
// Host serial master model for the half-bridge serial control block.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ps
module hhb_host_model (
  // Serial link
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  // ------
  // Frame task
  // ------
  // Clock stands still and data sits at pull-down level between frames
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic xfer(input logic [31:0] d, input int n, output logic [32:0] q);
    q = '0;
    #40 chip_select_n = 1'b0;
    #40 q = {q[31:0], serial_out};
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = d[i];
      #8 sclk = 1'b1;
      #16 sclk = 1'b0;
      q = {q[31:0], serial_out};
      #8;
    end
    serial_in = 1'b0;
    #40 chip_select_n = 1'b1;
    #5000;
  endtask
endmodule

// >>> hhb_serial_ctrl_tb_top.sv
// Self-checking bench for the half-bridge serial control block.
// Drives clock, enable and faults; the host model runs the link.
`timescale 1ns/1ps
module hhb_serial_ctrl_tb_top
  import hhb_pkg::*;
;
  typedef struct packed {
    hhb_fault_t flt;
    logic [15:0] cmd;
    logic [5:0] hs;
    logic [5:0] ls;
  } hhb_row_t;
  localparam hhb_row_t ROWS [7] = '{
    '{11'h000, 16'h1F80, 6'h00, 6'h3F},
    '{11'h040, 16'h1FFE, 6'h3F, 6'h00},
    '{11'h000, 16'h0A82, 6'h01, 6'h14},
    '{11'h400, 16'h1F81, 6'h00, 6'h00},
    '{11'h200, 16'h1F80, 6'h00, 6'h3F},
    '{11'h001, 16'h1F80, 6'h00, 6'h3F},
    '{11'h000, 16'h3F80, 6'h00, 6'h3E}
  };
  localparam int FE_N [3] = '{15, 20, 24};
  localparam logic [31:0] FE_D [3] = '{32'h00001FFE, 32'h00001FFE, 32'h00AB1FFE};
  localparam logic [5:0] FE_H [3] = '{6'h00, 6'h00, 6'h3F};
  logic mclk = 1'b0;
  logic rstn, device_enable, sclk, chip_select_n, serial_in, serial_out, serial_out_oe_n, device_ready;
  hhb_fault_t fault_in;
  logic [5:0] high_side_on, low_side_on;
  logic [32:0] q;
  hhb_row_t p = '0;
  logic uld_l = 1'b0;
  int n_errors = 0;
  int compares = 0;
  hhb_serial_ctrl DUT (.mclk, .rstn, .device_enable, .sclk, .chip_select_n, .serial_in, .serial_out,
    .serial_out_oe_n, .fault_in, .high_side_on, .low_side_on, .device_ready);
  hhb_host_model hm (.sclk, .chip_select_n, .serial_in, .serial_out);
  always #50 mclk = ~mclk;
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_drv(input logic [5:0] h, input logic [5:0] l);
    chk(33'({high_side_on, low_side_on}), 33'({h, l}));
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 1200 && device_ready !== 1'b1; k++) @(negedge mclk);
    chk(33'(device_ready), 33'h1);
  endtask
  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    #2000000;
    n_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
  end
  initial begin
    rstn = 1'b0;
    device_enable = 1'b1;
    fault_in = '0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    wait_ready();
    for (int i = 0; i < 7; i++) begin
      hm.xfer(32'(ROWS[i].cmd), 16, q);
      chk(q, {18'h0, p.flt.overvoltage | p.flt.undervoltage, uld_l, p.hs | p.ls, p.cmd[6:1], p.flt.thermal_warning});
      @(negedge mclk);
      fault_in <= ROWS[i].flt;
      repeat (8) @(negedge mclk);
      chk_drv(ROWS[i].hs, ROWS[i].ls);
      uld_l |= ROWS[i].flt.underload != 6'h00;
      p = ROWS[i];
    end
    // Latched thermal and overcurrent faults; early clear must be ignored
    fault_in <= 11'h180;
    repeat (10) @(negedge mclk);
    fault_in <= 11'h000;
    repeat (10) @(negedge mclk);
    chk_drv(6'h00, 6'h00);
    hm.xfer(32'h0000BF80, 16, q);
    chk(q, 33'h1A000);
    chk_drv(6'h00, 6'h00);
    repeat (1600) @(negedge mclk);
    hm.xfer(32'h0000BF80, 16, q);
    chk_drv(6'h00, 6'h3F);
    for (int i = 0; i < 3; i++) begin
      hm.xfer(FE_D[i], FE_N[i], q);
      chk_drv(FE_H[i], ~FE_H[i]);
    end
    hm.xfer(32'h12341F80, 32, q);
    chk(q, {1'b0, 16'h1FFE, 16'h1234});
    chk_drv(6'h00, 6'h3F);
    @(negedge mclk);
    device_enable <= 1'b0;
    repeat (10) @(negedge mclk);
    chk(33'({device_ready, high_side_on, low_side_on}), 33'h0);
    hm.xfer(32'h00001FFE, 16, q);
    @(negedge mclk);
    device_enable <= 1'b1;
    wait_ready();
    chk_drv(6'h00, 6'h00);
    hm.xfer(32'h0, 16, q);
    chk(q, 33'h0);
    results();
  end
endmodule
bind hhb_serial_ctrl hhb_serial_ctrl_properties u_props (.mclk, .rstn, .sclk, .device_enable, .chip_select_n,
  .serial_in, .fault_in, .serial_out, .serial_out_oe_n, .high_side_on, .low_side_on, .device_ready);
